// ---- mtc_pkg.sv ----
package mtc_pkg;

  // ==========================================================================
  // Widths and channel counts
  localparam int unsigned CNT_W = 16;
  localparam int unsigned NUM_CAP = 3;
  localparam int unsigned NUM_CMP = 5;
  localparam int unsigned PRE_SEL_W = 2;
  localparam int unsigned TICK_SEL_W = 2;

  // ==========================================================================
  // Interrupt source indices and count
  localparam int unsigned SRC_OVF = 0;
  localparam int unsigned SRC_TICK = 1;
  localparam int unsigned SRC_CAP0 = 2;
  localparam int unsigned SRC_CMP0 = SRC_CAP0 + NUM_CAP;
  localparam int unsigned NUM_SRC = SRC_CMP0 + NUM_CMP;
  localparam int unsigned SRC_IDX_W = 4;

  // ==========================================================================
  // Tap positions in the chain clocked directly by the system clock, beside the prescaler
  localparam int unsigned TICK_BASE_BIT = 13;
  localparam int unsigned WDOG_TAP_BIT = 16;
  localparam int unsigned CHAIN_W = 17;

  // ==========================================================================
  // Reset values
  localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;
  localparam logic [CHAIN_W-1:0] CHAIN_RST = 17'h00000;

  // Capture edge selection codes.
  typedef enum logic [1:0]
  {
    MTC_EDGE_OFF,
    MTC_EDGE_RISE,
    MTC_EDGE_FALL,
    MTC_EDGE_BOTH
  } mtc_edge_t;

endpackage : mtc_pkg

// ---- mtc_capture_chan.sv ----
`timescale 1ns/1ps
module mtc_capture_chan
#(
  parameter int unsigned CNT_W = 16
)
(
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // Pin and control
  input wire logic pin_i,
  input wire logic [1:0] edge_sel_i,
  input wire logic [CNT_W-1:0] count_i,
  // Results
  output logic [CNT_W-1:0] latch_o,
  output logic event_o
);

  // ==========================================================================
  // Synchroniser and edge detect
  logic meta_q;
  logic sync_q;
  logic last_q;
  logic [CNT_W-1:0] latch_q;
  logic [CNT_W-1:0] latch_d;
  logic hit;

  always_comb
  begin
    hit = 1'b0;
    unique case (mtc_pkg::mtc_edge_t'(edge_sel_i))
      mtc_pkg::MTC_EDGE_OFF: hit = 1'b0;
      mtc_pkg::MTC_EDGE_RISE: hit = sync_q & ~last_q; // R12
      mtc_pkg::MTC_EDGE_FALL: hit = ~sync_q & last_q; // R12
      mtc_pkg::MTC_EDGE_BOTH: hit = sync_q ^ last_q; // R12
    endcase
    latch_d = hit ? count_i : latch_q; // R3
  end

  // The first stage feeds only the second; edges are taken one stage later.
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      last_q <= 1'b0;
      latch_q <= '0;
    end
    else
    begin
      meta_q <= pin_i; // R10
      sync_q <= meta_q; // R10
      last_q <= sync_q;
      latch_q <= latch_d;
    end
  end

  assign latch_o = latch_q;
  assign event_o = hit;

endmodule : mtc_capture_chan

// ---- mtc_priority_enc.sv ----
`timescale 1ns/1ps
module mtc_priority_enc
#(
  parameter int unsigned NUM_SRC = 10,
  parameter int unsigned IDX_W = 4
)
(
  // Requests
  input wire logic [NUM_SRC-1:0] req_i,
  input wire logic [IDX_W-1:0] top_sel_i,
  input wire logic mask_i,
  // Winner
  output logic valid_o,
  output logic [IDX_W-1:0] vector_o
);

  // ==========================================================================
  // Default order: lowest index wins, unless the promoted source requests.
  always_comb
  begin
    valid_o = 1'b0;
    vector_o = '0;
    if (!mask_i) // R8
    begin
      for (int i = NUM_SRC - 1; i >= 0; i--)
      begin
        if (req_i[i])
        begin
          valid_o = 1'b1;
          vector_o = IDX_W'(i); // R9
        end
      end
      if ((32'(top_sel_i) < NUM_SRC) && req_i[top_sel_i])
      begin
        valid_o = 1'b1;
        vector_o = top_sel_i; // R9
      end
    end
  end

endmodule : mtc_priority_enc

// ---- mtc_main_timer.sv ----
`timescale 1ns/1ps
// Summary of operation
// R1 - A 16-bit counter runs freely from the clock behind a four-stage prescaler chosen by software.
// R2 - An overflow event is raised each time the counter wraps from all ones to zero.
// R3 - Each of three capture channels copies the counter into its latch on its selected pin edge.
// R4 - Five compare channels drive output pins and flag matches for software delays.
// R5 - A periodic tick is taken from the counter chain at one of four software-selected rates.
// R6 - The watchdog clock is a tap of the chain at the system clock divided by two to the 17th.
// R7 - Every timer event sets its status flag whether or not its interrupt is enabled.
// R8 - Timer requests are maskable and are recognised only while the global mask bit is clear.
// R9 - Sources follow a reset default order and software may promote one to the top.
// R10 - Asynchronous inputs such as the capture pins pass through synchronisers on one clock.
// R11 - Overflow, tick and every capture and compare channel have their own enable and vector.
// R12 - Control bits select which edge or edges of each capture input trigger a capture.
// R13 - The main counter is readable and has no write path at all.
// R14 - A compare channel matches on the prescaler step while its register equals the counter, and flags one clock later.
module mtc_main_timer
#(
  parameter int unsigned CNT_W = mtc_pkg::CNT_W,
  parameter int unsigned NUM_CAP = mtc_pkg::NUM_CAP,
  parameter int unsigned NUM_CMP = mtc_pkg::NUM_CMP
)
(
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // Prescaler and tick configuration
  input wire logic [mtc_pkg::PRE_SEL_W-1:0] prescale_sel_i,
  input wire logic [mtc_pkg::TICK_SEL_W-1:0] tick_rate_sel_i,
  // Capture pins and edge selection
  input wire logic [NUM_CAP-1:0] capture_pin_i,
  input wire logic [2*NUM_CAP-1:0] capture_edge_sel_i,
  // Compare values and output actions
  input wire logic [NUM_CMP*CNT_W-1:0] compare_value_i,
  input wire logic [NUM_CMP-1:0] compare_pin_en_i,
  input wire logic [NUM_CMP-1:0] compare_pin_level_i,
  // Interrupt enables, flag clear, priority and global mask
  input wire logic [mtc_pkg::NUM_SRC-1:0] irq_enable_i,
  input wire logic [mtc_pkg::NUM_SRC-1:0] flag_clear_i,
  input wire logic [mtc_pkg::SRC_IDX_W-1:0] top_priority_select_i,
  input wire logic condition_code_register_mask_i,
  // Counter and capture latches
  output logic [CNT_W-1:0] count_o,
  output logic [NUM_CAP*CNT_W-1:0] capture_latch_o,
  // Compare pins
  output logic [NUM_CMP-1:0] compare_pin_o,
  // Status, request and vector
  output logic [mtc_pkg::NUM_SRC-1:0] flags_o,
  output logic irq_o,
  output logic [mtc_pkg::SRC_IDX_W-1:0] irq_vector_o,
  // Chain taps
  output logic periodic_tick_interrupt_o,
  output logic watchdog_supervisor_clk_o
);

  localparam int unsigned NSRC = mtc_pkg::NUM_SRC;
  localparam int unsigned CW = mtc_pkg::CHAIN_W;

  // ==========================================================================
  // Prescaler
  logic [3:0] pre_q;
  logic [3:0] pre_d;
  logic pre_tick;

  // Divide by 1, 4, 8 or 16 from the prescale select.
  function automatic logic pre_done(input logic [1:0] sel, input logic [3:0] p);
    logic r;
    r = 1'b0;
    unique case (sel)
      2'h0: r = 1'b1;
      2'h1: r = (p[1:0] == 2'h3);
      2'h2: r = (p[2:0] == 3'h7);
      2'h3: r = (p == 4'hf);
    endcase
    return r;
  endfunction : pre_done

  always_comb
  begin
    pre_tick = pre_done(prescale_sel_i, pre_q); // R1
    pre_d = pre_tick ? 4'h0 : pre_q + 4'h1;
  end

  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      pre_q <= 4'h0;
    end
    else
    begin
      pre_q <= pre_d;
    end
  end

  // ==========================================================================
  // Free-running counter and overflow
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic ovf_evt;

  // There is no load path: software can only read the count.
  always_comb
  begin
    cnt_d = pre_tick ? cnt_q + 16'h0001 : cnt_q; // R1 R13
    ovf_evt = pre_tick && (cnt_q == 16'hffff); // R2
  end

  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      cnt_q <= mtc_pkg::CNT_RST;
    end
    else
    begin
      cnt_q <= cnt_d;
    end
  end

  // ==========================================================================
  // Counter chain
  logic [CW-1:0] chain_q;
  logic [CW-1:0] chain_d;

  // The chain counts raw clocks so the tick and watchdog rates ignore the prescale.
  always_comb
  begin
    chain_d = chain_q + 17'h00001;
  end

  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      chain_q <= mtc_pkg::CHAIN_RST;
    end
    else
    begin
      chain_q <= chain_d;
    end
  end

  // ==========================================================================
  // Periodic tick
  logic [3:0] tap_last_q;
  logic [3:0] tap_last_d;
  logic [3:0] taps;
  logic tick_evt;

  always_comb
  begin
    taps = chain_q[mtc_pkg::TICK_BASE_BIT +: 4];
    tap_last_d = taps;
    // A falling tap bit marks one full period of that rate.
    tick_evt = tap_last_q[tick_rate_sel_i] & ~taps[tick_rate_sel_i]; // R5
  end

  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      tap_last_q <= 4'h0;
    end
    else
    begin
      tap_last_q <= tap_last_d;
    end
  end

  // ==========================================================================
  // Watchdog tap
  logic wdog_last_q;
  logic wdog_last_d;
  logic wdog_q;
  logic wdog_d;

  // Only the rising edge of the tap bit pulses, so there is one pulse per full period.
  always_comb
  begin
    wdog_last_d = chain_q[mtc_pkg::WDOG_TAP_BIT];
    wdog_d = chain_q[mtc_pkg::WDOG_TAP_BIT] & ~wdog_last_q; // R6
  end

  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      wdog_last_q <= 1'b0;
      wdog_q <= 1'b0;
    end
    else
    begin
      wdog_last_q <= wdog_last_d;
      wdog_q <= wdog_d;
    end
  end

  // ==========================================================================
  // Capture channels
  logic [NUM_CAP-1:0] cap_evt;

  generate
    for (genvar c = 0; c < NUM_CAP; c++)
    begin : g_cap
      mtc_capture_chan #(.CNT_W(CNT_W)) u_cap
      (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .pin_i(capture_pin_i[c]),
        .edge_sel_i(capture_edge_sel_i[2*c +: 2]),
        .count_i(cnt_q),
        .latch_o(capture_latch_o[c*CNT_W +: CNT_W]), // R3
        .event_o(cap_evt[c])
      );
    end
  endgenerate

  // ==========================================================================
  // Compare channels
  logic [NUM_CMP-1:0] cmp_evt;
  logic [NUM_CMP-1:0] cmp_pin_q;
  logic [NUM_CMP-1:0] cmp_pin_d;

  // A match is reported once per counter value, on the prescaler step.
  generate
    for (genvar k = 0; k < NUM_CMP; k++)
    begin : g_cmp
      assign cmp_evt[k] = pre_tick && (cnt_q == compare_value_i[k*CNT_W +: CNT_W]); // R14
    end
  endgenerate

  // A channel without its pin enable keeps its pin, so it can serve as a plain delay.
  always_comb
  begin
    for (int j = 0; j < NUM_CMP; j++)
    begin
      if (cmp_evt[j] && compare_pin_en_i[j])
      begin
        cmp_pin_d[j] = compare_pin_level_i[j]; // R4
      end
      else
      begin
        cmp_pin_d[j] = cmp_pin_q[j];
      end
    end
  end

  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      cmp_pin_q <= '0;
    end
    else
    begin
      cmp_pin_q <= cmp_pin_d;
    end
  end

  // ==========================================================================
  // Status flags
  logic [NSRC-1:0] flag_q;
  logic [NSRC-1:0] flag_d;
  logic [NSRC-1:0] evt;

  always_comb
  begin
    evt = {cmp_evt, cap_evt, tick_evt, ovf_evt};
    // A clear is a level, so a bit stays clear while its clear is held, except in the cycle after its event.
    // Set wins over a clear in the same cycle so no event is lost.
    flag_d = (flag_q & ~flag_clear_i) | evt; // R7
  end

  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      flag_q <= '0;
    end
    else
    begin
      flag_q <= flag_d;
    end
  end

  // ==========================================================================
  // Interrupt request selection
  logic [NSRC-1:0] irq_req;

  // Disabled sources keep their flags but never reach the request logic.
  always_comb
  begin
    irq_req = flag_q & irq_enable_i; // R11
  end

  mtc_priority_enc #(.NUM_SRC(NSRC), .IDX_W(mtc_pkg::SRC_IDX_W)) u_prio
  (
    .req_i(irq_req),
    .top_sel_i(top_priority_select_i),
    .mask_i(condition_code_register_mask_i),
    .valid_o(irq_o),
    .vector_o(irq_vector_o)
  );

  assign count_o = cnt_q; // R13
  assign compare_pin_o = cmp_pin_q;
  assign flags_o = flag_q;
  assign periodic_tick_interrupt_o = tick_evt;
  assign watchdog_supervisor_clk_o = wdog_q;

endmodule : mtc_main_timer

// ---- mtc_main_timer_properties.sv ----
`timescale 1ns/1ps
// ============================================================================
// Port checks for the main timer
module mtc_main_timer_checker
#(
  parameter int unsigned CNT_W = 16,
  parameter int unsigned NUM_CAP = 3,
  parameter int unsigned NUM_CMP = 5
)
(
  // Clock, reset and controls
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic [NUM_CMP*CNT_W-1:0] compare_value_i,
  input wire logic [mtc_pkg::NUM_SRC-1:0] irq_enable_i,
  input wire logic [mtc_pkg::SRC_IDX_W-1:0] top_priority_select_i,
  input wire logic condition_code_register_mask_i,
  // Observed outputs
  input wire logic [CNT_W-1:0] count_o,
  input wire logic [NUM_CAP*CNT_W-1:0] capture_latch_o,
  input wire logic [mtc_pkg::NUM_SRC-1:0] flags_o,
  input wire logic irq_o,
  input wire logic [mtc_pkg::SRC_IDX_W-1:0] irq_vector_o,
  input wire logic periodic_tick_interrupt_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);

  a_count_step: assert property ($changed(count_o) |-> count_o == $past(count_o) + 16'h1)
    else $error("counter moved by other than one");
  a_ovf_flag: assert property ($past(count_o) == 16'hffff && count_o == 16'h0 |-> flags_o[0])
    else $error("wrap without overflow flag");
  a_irq_masked: assert property (condition_code_register_mask_i |-> !irq_o)
    else $error("request while masked");
  a_irq_level: assert property (irq_o == (!condition_code_register_mask_i
    && |(flags_o & irq_enable_i)))
    else $error("request differs from enabled flags");
  a_cmp_flag: assert property ($changed(count_o)
    && $past(count_o) == $past(compare_value_i[15:0]) |-> flags_o[5])
    else $error("compare match without flag");
  a_cap_flag: assert property ($changed(capture_latch_o[15:0]) |-> flags_o[2])
    else $error("capture without flag");
  a_tick_flag: assert property (periodic_tick_interrupt_o |=> flags_o[1]
    && !periodic_tick_interrupt_o)
    else $error("tick not flagged or too long");
  a_top_vector: assert property (!condition_code_register_mask_i
    && top_priority_select_i < 4'ha && flags_o[top_priority_select_i]
    && irq_enable_i[top_priority_select_i] |-> irq_vector_o == top_priority_select_i)
    else $error("promoted source lost");
endmodule : mtc_main_timer_checker

bind mtc_main_timer mtc_main_timer_checker #(.CNT_W(CNT_W), .NUM_CAP(NUM_CAP),
  .NUM_CMP(NUM_CMP)) i_chk (.*);

// ---- testbench.sv ----
`timescale 1ns/1ps
// ============================================================================
// Bench for the main timer
module testbench;
  logic clock_i;
  logic rst_i;
  logic [1:0] prescale_sel_i;
  logic [1:0] tick_rate_sel_i;
  logic [2:0] capture_pin_i;
  logic [5:0] capture_edge_sel_i;
  logic [79:0] compare_value_i;
  logic [4:0] compare_pin_en_i;
  logic [4:0] compare_pin_level_i;
  logic [9:0] irq_enable_i;
  logic [9:0] flag_clear_i;
  logic [3:0] top_priority_select_i;
  logic condition_code_register_mask_i;
  logic [15:0] count_o;
  logic [47:0] capture_latch_o;
  logic [4:0] compare_pin_o;
  logic [9:0] flags_o;
  logic irq_o;
  logic [3:0] irq_vector_o;
  logic periodic_tick_interrupt_o;
  logic watchdog_supervisor_clk_o;
  int num_errors = 0;
  int n_compared = 0;
  int cyc = 0;
  int last_tick = 0;
  int n_wdog = 0;
  int rel_cyc = 0;
  int k;
  logic [15:0] c;
  logic e;

  mtc_main_timer i_dut (.*);

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("wrong value %s: expected %h, seen %h", what, exp, seen);
    end
  endtask : check

  task automatic complete_run();
    $display("Checks %0d, mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : complete_run

  task automatic step(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask : step

  // Waiting for two steps hides the unknown prescaler phase after a change.
  task automatic wait_change();
    logic [15:0] v;
    v = count_o;
    for (int i = 0; i < 40 && count_o === v; i++)
      step(1);
  endtask : wait_change

  task automatic clear_flags();
    @(posedge clock_i);
    flag_clear_i <= 10'h3ff;
    @(posedge clock_i);
    flag_clear_i <= 10'h0;
    step(1);
  endtask : clear_flags

  initial
  begin
    clock_i = 1'b0;
    forever #2 clock_i = ~clock_i;
  end

  // Pulses are sampled mid-cycle, away from the edge that launches them.
  always @(negedge clock_i)
  begin
    cyc++;
    if (watchdog_supervisor_clk_o === 1'b1)
    begin
      n_wdog++;
      check("watchdog delay", 16'(cyc - rel_cyc - 32'h10000), 16'h0002);
    end
    if (periodic_tick_interrupt_o === 1'b1)
    begin
      if (last_tick > 0)
        check("tick gap", 16'(cyc - last_tick), 16'(32'h4000 << tick_rate_sel_i));
      last_tick = cyc;
    end
  end

  initial
  begin
    repeat (100000) @(posedge clock_i);
    num_errors++;
    complete_run();
  end

  initial
  begin
    rst_i = 1'b1;
    prescale_sel_i = 2'h3;
    tick_rate_sel_i = 2'h0;
    capture_pin_i = 3'h0;
    capture_edge_sel_i = 6'h0;
    compare_value_i = 80'h0;
    compare_pin_en_i = 5'h0;
    compare_pin_level_i = 5'h0;
    irq_enable_i = 10'h0;
    flag_clear_i = 10'h0;
    top_priority_select_i = 4'hf;
    condition_code_register_mask_i = 1'b1;
    step(11);
    check("reset count", count_o, 16'h0);
    check("reset flags", flags_o, 16'h0);
    @(posedge clock_i);
    rst_i <= 1'b0;
    rel_cyc = cyc;
    for (int s = 3; s >= 0; s--)
    begin
      @(posedge clock_i);
      prescale_sel_i <= 2'(s);
      wait_change();
      wait_change();
      c = count_o;
      step(4 * (s == 0 ? 1 : 2 << s));
      check("count step", count_o, c + 16'h4);
    end
    clear_flags();
    c = count_o;
    @(posedge clock_i);
    for (k = 0; k < 5; k++)
      compare_value_i[16*k +: 16] <= c + 16'(24 + k);
    compare_pin_en_i <= 5'h1f;
    compare_pin_level_i <= 5'h15;
    step(40);
    check("compare flags", flags_o[9:5], 5'h1f);
    check("compare pins", compare_pin_o, 5'h15);
    @(posedge clock_i);
    irq_enable_i <= 10'h3e0;
    step(1);
    check("masked request", irq_o, 1'b0);
    @(posedge clock_i);
    condition_code_register_mask_i <= 1'b0;
    step(1);
    check("request", irq_o, 1'b1);
    check("default vector", irq_vector_o, 4'h5);
    @(posedge clock_i);
    top_priority_select_i <= 4'h8;
    step(1);
    check("promoted vector", irq_vector_o, 4'h8);
    @(posedge clock_i);
    irq_enable_i <= 10'h0;
    step(1);
    check("disabled request", irq_o, 1'b0);
    check("flags kept", flags_o[9:5], 5'h1f);
    for (int m = 0; m < 4; m++)
      for (int r = 1; r >= 0; r--)
      begin
        clear_flags();
        @(posedge clock_i);
        capture_edge_sel_i <= {3{2'(m)}};
        step(4);
        @(posedge clock_i);
        capture_pin_i <= {3{r[0]}};
        step(0);
        c = count_o;
        e = (m == 3 || m == 2 - r);
        step(2);
        check("early capture", flags_o[4:2], 3'h0);
        step(1);
        check("capture flags", flags_o[4:2], {3{e}});
        for (k = 0; k < 3 && e; k++)
          check("capture latch", capture_latch_o[16*k +: 16], c + 16'h2);
      end
    clear_flags();
    for (k = 0; k < 70000 && count_o !== 16'ha000; k++)
      step(1);
    @(posedge clock_i);
    tick_rate_sel_i <= 2'h1;
    for (k = 0; k < 70000 && count_o !== 16'hffff; k++)
      step(1);
    step(1);
    check("wrap count", count_o, 16'h0);
    check("overflow flag", flags_o[0], 1'b1);
    check("watchdog pulses", 16'(n_wdog), 16'h1);
    complete_run();
  end
endmodule : testbench
